/* src/test_xfer_pkg.sv */
// constants for the test, copy and wait decoder
package test_xfer_pkg;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_TEST_DIR = 8'h3d;
    localparam logic [7:0] OP_TEST_ACC = 8'h4d;
    localparam logic [7:0] OP_TEST_IDX = 8'h5d;
    localparam logic [7:0] OP_TEST_IX1 = 8'h6d;
    localparam logic [7:0] OP_TEST_IX = 8'h7d;
    localparam logic [7:0] OP_COPY_IDX = 8'h9f;
    localparam logic [7:0] OP_WAIT = 8'h8f;
    localparam logic [3:0] HI_BIT_BRANCH = 4'h0;
    localparam logic [3:0] HI_WORD_IDX = 4'hd;
    // ----------------------------------------------------------------
    // cycle counts per instruction
    // ----------------------------------------------------------------
    localparam logic [3:0] CYC_TEST_DIR = 4'h4;
    localparam logic [3:0] CYC_TEST_REG = 4'h3;
    localparam logic [3:0] CYC_TEST_IX1 = 4'h5;
    localparam logic [3:0] CYC_TEST_IX = 4'h4;
    localparam logic [3:0] CYC_COPY = 4'h2;
    localparam logic [3:0] CYC_WAIT = 4'h2;
    localparam logic [3:0] CYC_HANDOFF = 4'h1;
    // ----------------------------------------------------------------
    // operand byte counts and result fields
    // ----------------------------------------------------------------
    localparam logic [1:0] NEED_NONE = 2'h0;
    localparam logic [1:0] NEED_ONE = 2'h1;
    localparam logic [1:0] NEED_TWO = 2'h2;
    localparam int SIGN_BIT = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ZERO_ADDR = 16'h0000;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_DIRECT,
        MODE_BYTE_OFS,
        MODE_WORD_OFS
    } addr_mode_t;
endpackage

/* src/operand_if.sv */
// operand byte carrier between decoder and collector
`timescale 1ns/100ps
`default_nettype none
interface operand_if;
    logic start;
    logic [1:0] need;
    logic byte_valid;
    logic [7:0] byte_data;
    logic byte_req;
    logic ready;
    logic [7:0] first_b;
    logic [7:0] second_b;

    modport collector (input start, need, byte_valid, byte_data, output byte_req, ready, first_b, second_b);
    modport decoder (output start, need, byte_valid, byte_data, input byte_req, ready, first_b, second_b);
endinterface
`default_nettype wire

/* src/operand_collect.sv */
// gathers up to two operand bytes in fetch order
`timescale 1ns/100ps
`default_nettype none
module operand_collect (
    input wire logic clk,
    input wire logic reset,
    operand_if.collector ops
);
    logic [1:0] left_q, left_d;
    logic [7:0] first_q, second_q;
    logic ready_q;
    wire take = ops.byte_req && ops.byte_valid;

    // ----------------------------------------------------------------
    // byte counting
    // ----------------------------------------------------------------
    assign ops.byte_req = (left_q != test_xfer_pkg::NEED_NONE);
    assign left_d = ops.start ? ops.need : (take ? left_q - 2'h1 : left_q);
    assign ops.ready = ready_q;
    assign ops.first_b = first_q;
    assign ops.second_b = second_q;

    // first byte is high/address byte, second is low/offset byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            left_q <= test_xfer_pkg::NEED_NONE;
            first_q <= test_xfer_pkg::ZERO_BYTE;
            second_q <= test_xfer_pkg::ZERO_BYTE;
            ready_q <= 1'b0;
        end else begin
            left_q <= left_d;
            ready_q <= take && (left_q == test_xfer_pkg::NEED_ONE);
            if (take) begin
                first_q <= (left_q == test_xfer_pkg::NEED_TWO || ops.need == test_xfer_pkg::NEED_ONE) ?
                           ops.byte_data : first_q;
                second_q <= ops.byte_data;
            end
        end
    end
endmodule // operand_collect
`default_nettype wire

/* src/test_xfer_decode.sv */
// decoder and sequencer for test, copy-index and wait instructions
`timescale 1ns/100ps
`default_nettype none
module test_xfer_decode (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic OPCODE_VALID,
    input wire logic [7:0] OPCODE,
    output logic OPCODE_READY,
    output logic OPERAND_REQ,
    input wire logic OPERAND_VALID,
    input wire logic [7:0] OPERAND,
    input wire logic [7:0] ACC_IN,
    input wire logic [7:0] INDEX_IN,
    output logic MEM_RD_REQ,
    input wire logic MEM_RD_VALID,
    input wire logic [7:0] MEM_RD_DATA,
    input wire logic IRQ_PENDING,
    output logic [15:0] EFF_ADDR,
    output logic [7:0] BRANCH_OFFSET,
    output logic DONE,
    output logic ACC_LOAD,
    output logic [7:0] ACC_OUT,
    output logic FLAGS_WE,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic CLEAR_IMASK,
    output logic CPU_HALT,
    output logic START_ISR,
    output logic HANDOFF,
    output logic [7:0] HANDOFF_OPCODE
);
    typedef enum logic [2:0] {S_IDLE, S_OPERANDS, S_MEMRD, S_RUN, S_HALTED} state_t;
    state_t state_q, state_d;
    operand_if ops ();

    logic [7:0] op_q;
    logic [3:0] cnt_q;
    logic [15:0] ea_q;
    logic [7:0] ofs_q, mem_q;
    logic done_q, acc_load_q, flags_we_q, clr_imask_q, isr_q, handoff_q;
    logic [7:0] acc_q;
    logic n_q, z_q;

    // ----------------------------------------------------------------
    // opcode decode
    // ----------------------------------------------------------------
    wire accept = (state_q == S_IDLE) && OPCODE_VALID;
    wire [7:0] op_now = accept ? OPCODE : op_q;
    wire is_test_dir = (op_now == test_xfer_pkg::OP_TEST_DIR);
    wire is_test_acc = (op_now == test_xfer_pkg::OP_TEST_ACC);
    wire is_test_idx = (op_now == test_xfer_pkg::OP_TEST_IDX);
    wire is_test_ix1 = (op_now == test_xfer_pkg::OP_TEST_IX1);
    wire is_test_ix = (op_now == test_xfer_pkg::OP_TEST_IX);
    wire is_copy = (op_now == test_xfer_pkg::OP_COPY_IDX);
    wire is_wait = (op_now == test_xfer_pkg::OP_WAIT);
    wire is_bit_br = (op_now[7:4] == test_xfer_pkg::HI_BIT_BRANCH);
    wire is_word = (op_now[7:4] == test_xfer_pkg::HI_WORD_IDX);
    wire is_test = is_test_dir || is_test_acc || is_test_idx || is_test_ix1 || is_test_ix;
    wire needs_mem = is_test_dir || is_test_ix1 || is_test_ix;
    test_xfer_pkg::addr_mode_t mode;
    assign mode = (is_test_dir || is_bit_br) ? test_xfer_pkg::MODE_DIRECT :
                  is_test_ix1 ? test_xfer_pkg::MODE_BYTE_OFS :
                  is_word ? test_xfer_pkg::MODE_WORD_OFS : test_xfer_pkg::MODE_NONE;
    wire [1:0] need = (is_bit_br || is_word) ? test_xfer_pkg::NEED_TWO :
                      (is_test_dir || is_test_ix1) ? test_xfer_pkg::NEED_ONE : test_xfer_pkg::NEED_NONE;
    wire [3:0] cycles = is_test_dir ? test_xfer_pkg::CYC_TEST_DIR :
                        (is_test_acc || is_test_idx) ? test_xfer_pkg::CYC_TEST_REG :
                        is_test_ix1 ? test_xfer_pkg::CYC_TEST_IX1 :
                        is_test_ix ? test_xfer_pkg::CYC_TEST_IX :
                        is_copy ? test_xfer_pkg::CYC_COPY :
                        is_wait ? test_xfer_pkg::CYC_WAIT : test_xfer_pkg::CYC_HANDOFF;

    // ----------------------------------------------------------------
    // operand bytes and effective address
    // ----------------------------------------------------------------
    assign ops.start = accept && (need != test_xfer_pkg::NEED_NONE);
    assign ops.need = need;
    assign ops.byte_valid = OPERAND_VALID;
    assign ops.byte_data = OPERAND;
    assign OPERAND_REQ = ops.byte_req;

    operand_collect u_collect (
        .clk(CLK),
        .reset(RESET),
        .ops(ops)
    );

    // direct, byte offset from index, word offset from index
    wire [15:0] ea_next = (mode == test_xfer_pkg::MODE_DIRECT) ? {test_xfer_pkg::ZERO_BYTE, ops.first_b} :
                          (mode == test_xfer_pkg::MODE_BYTE_OFS) ?
                              16'({test_xfer_pkg::ZERO_BYTE, ops.first_b} + {test_xfer_pkg::ZERO_BYTE, INDEX_IN}) :
                          (mode == test_xfer_pkg::MODE_WORD_OFS) ?
                              16'({ops.first_b, ops.second_b} + {test_xfer_pkg::ZERO_BYTE, INDEX_IN}) :
                          {test_xfer_pkg::ZERO_BYTE, INDEX_IN};

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    wire min_met = (cnt_q >= cycles - 4'h1);
    // one-cycle opcodes end in their own opcode cycle, with no run state
    wire quick = accept && (need == test_xfer_pkg::NEED_NONE) && !needs_mem &&
                 (cycles == test_xfer_pkg::CYC_HANDOFF);
    // read data may end the instruction at once, so the read costs no extra cycle
    wire mem_take = (state_q == S_MEMRD) && MEM_RD_VALID;
    wire [7:0] mem_now = mem_take ? MEM_RD_DATA : mem_q;
    wire finish = (((state_q == S_RUN) || mem_take) && min_met) || quick;
    wire wake = (state_q == S_HALTED) && IRQ_PENDING;
    wire [7:0] test_val = is_test_acc ? ACC_IN : (is_test_idx ? INDEX_IN : mem_now);

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: if (accept) state_d = quick ? S_IDLE : (need != test_xfer_pkg::NEED_NONE) ? S_OPERANDS :
                                          needs_mem ? S_MEMRD : S_RUN;
            S_OPERANDS: if (ops.ready) state_d = needs_mem ? S_MEMRD : S_RUN;
            S_MEMRD: if (MEM_RD_VALID) state_d = min_met ? S_IDLE : S_RUN;
            S_RUN: if (min_met) state_d = is_wait ? S_HALTED : S_IDLE;
            S_HALTED: if (IRQ_PENDING) state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // instruction context; counter starts at one after the opcode cycle
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= S_IDLE;
            op_q <= test_xfer_pkg::ZERO_BYTE;
            cnt_q <= 4'h0;
            ea_q <= test_xfer_pkg::ZERO_ADDR;
            ofs_q <= test_xfer_pkg::ZERO_BYTE;
            mem_q <= test_xfer_pkg::ZERO_BYTE;
        end else begin
            state_q <= state_d;
            op_q <= op_now;
            cnt_q <= accept ? 4'h1 : ((cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1);
            if (accept || ops.ready) ea_q <= ea_next;
            if (ops.ready) ofs_q <= ops.second_b;
            if (state_q == S_MEMRD && MEM_RD_VALID) mem_q <= MEM_RD_DATA;
        end
    end

    // completion effects, registered so data and strobes line up
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            done_q <= 1'b0;
            acc_load_q <= 1'b0;
            flags_we_q <= 1'b0;
            clr_imask_q <= 1'b0;
            isr_q <= 1'b0;
            handoff_q <= 1'b0;
            acc_q <= test_xfer_pkg::ZERO_BYTE;
            n_q <= 1'b0;
            z_q <= 1'b0;
        end else begin
            done_q <= finish;
            acc_load_q <= finish && is_copy;
            flags_we_q <= finish && is_test;
            clr_imask_q <= finish && is_wait;
            isr_q <= wake;
            handoff_q <= finish && !is_test && !is_copy && !is_wait;
            if (finish && is_copy) acc_q <= INDEX_IN;
            if (finish && is_test) begin
                n_q <= test_val[test_xfer_pkg::SIGN_BIT];
                z_q <= (test_val == test_xfer_pkg::ZERO_BYTE);
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign OPCODE_READY = (state_q == S_IDLE);
    assign MEM_RD_REQ = (state_q == S_MEMRD);
    assign EFF_ADDR = ea_q;
    assign BRANCH_OFFSET = ofs_q;
    assign DONE = done_q;
    assign ACC_LOAD = acc_load_q;
    assign ACC_OUT = acc_q;
    assign FLAGS_WE = flags_we_q;
    assign FLAG_N = n_q;
    assign FLAG_Z = z_q;
    assign CLEAR_IMASK = clr_imask_q;
    assign CPU_HALT = (state_q == S_HALTED);
    assign START_ISR = isr_q;
    assign HANDOFF = handoff_q;
    assign HANDOFF_OPCODE = op_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_copy_issue;
        accept && OPCODE == test_xfer_pkg::OP_COPY_IDX;
    endsequence
    sequence s_wait_issue;
        accept && OPCODE == test_xfer_pkg::OP_WAIT;
    endsequence

    a_copy_two_cycles: assert property (@(posedge CLK) disable iff (RESET)
        s_copy_issue |-> ##1 !DONE ##1 (DONE && ACC_LOAD && !FLAGS_WE && ACC_OUT == $past(INDEX_IN)))
        else $error("copy index did not load accumulator in two cycles");
    a_wait_halts: assert property (@(posedge CLK) disable iff (RESET)
        s_wait_issue |-> ##2 (CLEAR_IMASK && DONE && CPU_HALT))
        else $error("wait did not clear mask and halt in two cycles");
    a_halt_holds: assert property (@(posedge CLK) disable iff (RESET)
        CPU_HALT && !IRQ_PENDING |=> CPU_HALT)
        else $error("halt released without interrupt");
    a_halt_wakes: assert property (@(posedge CLK) disable iff (RESET)
        CPU_HALT && IRQ_PENDING |=> (!CPU_HALT && START_ISR))
        else $error("interrupt did not restart from halt");
    a_test_flags: assert property (@(posedge CLK) disable iff (RESET)
        FLAGS_WE |-> (!ACC_LOAD && FLAG_N == $past(test_val[test_xfer_pkg::SIGN_BIT])
                      && FLAG_Z == ($past(test_val) == test_xfer_pkg::ZERO_BYTE)))
        else $error("test flags wrong or something stored");
    a_test_reg_time: assert property (@(posedge CLK) disable iff (RESET)
        accept && OPCODE == test_xfer_pkg::OP_TEST_ACC |-> ##3 FLAGS_WE)
        else $error("accumulator test not done in three cycles");
    a_bit_operands: assert property (@(posedge CLK) disable iff (RESET)
        HANDOFF && op_q[7:4] == test_xfer_pkg::HI_BIT_BRANCH |->
            (EFF_ADDR == {test_xfer_pkg::ZERO_BYTE, ops.first_b} && BRANCH_OFFSET == ops.second_b))
        else $error("branch-on-bit operands misplaced");
    a_word_offset: assert property (@(posedge CLK) disable iff (RESET)
        ops.ready && is_word |=> EFF_ADDR == 16'({$past(ops.first_b), $past(ops.second_b)}
                                                 + {test_xfer_pkg::ZERO_BYTE, $past(INDEX_IN)}))
        else $error("word offset address wrong");
endmodule // test_xfer_decode
`default_nettype wire

/* sim/cpu_test_transfer_wait_ops_bench.sv */
// self-checking bench for the test, copy-index and wait decoder
`timescale 1ns/100ps
`default_nettype none
module cpu_test_transfer_wait_ops_bench;
    logic clk, reset, opcode_valid, operand_valid, mem_rd_valid, irq_pending;
    logic [7:0] opcode, operand, acc_in, index_in, mem_rd_data;
    wire logic opcode_ready, operand_req, mem_rd_req, done, acc_load, flags_we, flag_n, flag_z;
    wire logic clear_imask, cpu_halt, start_isr, handoff;
    wire logic [15:0] eff_addr;
    wire logic [7:0] branch_offset, acc_out, handoff_opcode;
    wire logic [3:0] pulses = {acc_load, flags_we, clear_imask, handoff};
    logic [7:0] test_ops [5] = '{8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d};
    int test_cyc [5] = '{4, 3, 3, 5, 4};
    int errors = 0;
    int n_tests = 0;

    test_xfer_decode DUT (.CLK(clk), .RESET(reset), .OPCODE_VALID(opcode_valid), .OPCODE(opcode),
        .OPCODE_READY(opcode_ready), .OPERAND_REQ(operand_req), .OPERAND_VALID(operand_valid), .OPERAND(operand),
        .ACC_IN(acc_in), .INDEX_IN(index_in), .MEM_RD_REQ(mem_rd_req), .MEM_RD_VALID(mem_rd_valid),
        .MEM_RD_DATA(mem_rd_data), .IRQ_PENDING(irq_pending), .EFF_ADDR(eff_addr), .BRANCH_OFFSET(branch_offset),
        .DONE(done), .ACC_LOAD(acc_load), .ACC_OUT(acc_out), .FLAGS_WE(flags_we), .FLAG_N(flag_n),
        .FLAG_Z(flag_z), .CLEAR_IMASK(clear_imask), .CPU_HALT(cpu_halt), .START_ISR(start_isr),
        .HANDOFF(handoff), .HANDOFF_OPCODE(handoff_opcode));

    // 100 mhz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // one counted comparison; case inequality so unknowns never match
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // expected negative and zero flags of a tested byte
    function automatic logic [1:0] nz(input logic [7:0] v);
        return {v[7], v == 8'h00};
    endfunction

    // inputs always move 1 ns after the rising edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    // offer one opcode, feed its operand bytes and memory data, count edges up to done
    task automatic run_op(input logic [7:0] op, b1, b2, md, input int nb, input bit slow, output int cyc);
        int idx;
        bit req_p;
        idx = 0;
        cyc = 1; // the opcode cycle counts as the first
        opcode = op;
        opcode_valid = 1'b1;
        tick;
        opcode_valid = 1'b0;
        opcode = ~op; // stale opcode lines must not matter once taken
        while (done !== 1'b1) begin
            // a raised valid stays up until taken; slow mode only delays raising it
            operand_valid = operand_req && idx < nb && (operand_valid || !slow || $urandom_range(1) == 1);
            operand = (idx == 0) ? b1 : b2;
            mem_rd_valid = mem_rd_req && (mem_rd_valid || !slow || $urandom_range(1) == 1);
            mem_rd_data = mem_rd_valid ? md : ~md;
            req_p = operand_req;
            tick;
            cyc++;
            if (operand_valid && req_p) begin
                idx++;
            end
            if (cyc > 40) begin
                check("done within bound", 16'h0000, 16'h0001);
                stop_test;
            end
        end
        operand_valid = 1'b0;
        mem_rd_valid = 1'b0;
    endtask

    // main sequence
    initial begin
        logic [7:0] op, v, b1, b2;
        logic [1:0] f;
        int cyc;
        int k;
        {reset, opcode_valid, operand_valid, mem_rd_valid, irq_pending} = 5'h10;
        {opcode, operand, acc_in, index_in, mem_rd_data} = 40'h0;
        void'($urandom(32'hfb5c));
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        check("idle after reset", {opcode_ready, cpu_halt, start_isr, done, pulses}, 8'h80);
        // test ops: zero, sign-only and random bytes; other registers get the sign flipped, memory gets the inverted byte on register tests
        for (int i = 0; i < 20; i++) begin
            op = test_ops[i % 5];
            v = (i < 5) ? 8'h00 : (i < 10) ? 8'h80 : 8'($urandom);
            b1 = 8'($urandom);
            acc_in = (op == 8'h4d) ? v : v ^ 8'h80;
            index_in = (op == 8'h5d) ? v : v ^ 8'h80;
            run_op(op, b1, 8'h00, (op == 8'h4d || op == 8'h5d) ? ~v : v, (op == 8'h3d || op == 8'h6d), i >= 15, cyc);
            check("test flags", {flag_n, flag_z}, nz(v));
            check("test pulses", pulses, 4'h4);
            if (i < 15) begin
                check("test cycles", 16'(cyc), 16'(test_cyc[i % 5]));
            end
            if (op == 8'h3d || op == 8'h6d || op == 8'h7d) begin
                check("test address", eff_addr, (op == 8'h3d) ? {8'h00, b1} :
                    (op == 8'h6d) ? {8'h00, b1} + {8'h00, index_in} : {8'h00, index_in});
            end
        end
        // copy index, back to back; flags must survive untouched
        for (int i = 0; i < 4; i++) begin
            f = {flag_n, flag_z};
            index_in = (i == 0) ? 8'h00 : 8'($urandom);
            acc_in = ~index_in;
            run_op(8'h9f, 8'h00, 8'h00, 8'h00, 0, 1'b0, cyc);
            check("copy cycles", 16'(cyc), 16'h0002);
            check("copy value", {8'h00, acc_out}, {8'h00, index_in});
            check("copy pulses", pulses, 4'h8);
            check("copy flags", {flag_n, flag_z}, f);
        end
        // bit-branch, word-offset and foreign opcodes pass on with their operands
        for (int i = 0; i < 24; i++) begin
            k = i % 3;
            op = (k == 0) ? {4'h0, 4'($urandom)} : (k == 1) ? {4'hd, 4'($urandom)} : 8'(8'h20 + i);
            b1 = (i == 1) ? 8'hff : 8'($urandom);
            b2 = (i == 1) ? 8'hff : 8'($urandom);
            index_in = (i == 1) ? 8'hff : 8'($urandom);
            run_op(op, b1, b2, 8'h00, (k < 2) ? 2 : 0, i % 2 == 1, cyc);
            check("handoff pulses", pulses, 4'h1);
            check("handoff opcode", {8'h00, handoff_opcode}, {8'h00, op});
            if (k == 0) begin
                check("bit address", eff_addr, {8'h00, b1});
                check("branch offset", {8'h00, branch_offset}, {8'h00, b2});
            end else if (k == 1) begin
                check("word offset address", eff_addr, {b1, b2} + {8'h00, index_in});
            end else if (i % 2 == 0) begin
                check("handoff cycles", 16'(cyc), 16'h0001);
            end
        end
        // wait: halt and refuse opcodes; first wakes on interrupt, second is cut by reset
        for (int i = 0; i < 2; i++) begin
            run_op(8'h8f, 8'h00, 8'h00, 8'h00, 0, 1'b0, cyc);
            check("wait cycles", 16'(cyc), 16'h0002);
            check("wait pulses", {pulses, cpu_halt}, 5'h05);
            opcode = 8'h9f;
            opcode_valid = 1'b1;
            k = $urandom_range(6, 1);
            repeat (k) begin
                tick;
                check("held while halted", {cpu_halt, opcode_ready, done, start_isr}, 4'h8);
            end
            opcode_valid = 1'b0;
            irq_pending = (i == 0);
            reset = (i == 1);
            tick;
            irq_pending = 1'b0;
            reset = 1'b0;
            check("wake", {cpu_halt, start_isr, opcode_ready}, (i == 0) ? 3'h3 : 3'h1);
        end
        stop_test;
    end
endmodule // cpu_test_transfer_wait_ops_bench
`default_nettype wire
